// ===== logic/pms_pkg.sv
// Package: constants and types of the precession measurement sequencer
package pms_pkg;

	// Clock and time base
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;

	// Phase lengths in milliseconds
	localparam logic [11:0] POL_NORM_MS = 12'h0708; // 1800 ms
	localparam logic [11:0] POL_LONG_MS = 12'h0B54; // 2900 ms
	localparam logic [11:0] POL_SHORT_MS = 12'h0384; // 900 ms
	localparam logic [11:0] EXTRA_MS = 12'h03E8; // 1000 ms hold-over
	localparam logic [11:0] CNT_NORM_MS = 12'h0398; // 920 ms
	localparam logic [11:0] CNT_SHORT_MS = 12'h01CC; // 460 ms
	localparam logic [11:0] BEEP_MS = 12'h0064; // 100 ms per half beep
	localparam logic [3:0] BEEP_PHASES = 4'hA; // Five on, five off
	localparam int unsigned BLANK_MS = 300_000; // Five minutes
	localparam logic [1:0] SETTLE_CYC = 2'h3;
	localparam logic [1:0] AVG_LAST = 2'h2; // Index of third reading

	// Counts to tenths of nT, Q8; short window doubles the weight
	localparam logic [17:0] SCALE_NORM = 18'h0_FF4C;
	localparam logic [17:0] SCALE_SHORT = 18'h1_FE97;
	localparam logic [15:0] THIRD_Q16 = 16'h5556;

	// Baud rates by switch code
	localparam logic [16:0] BAUD_0 = 17'h1_C200;
	localparam logic [16:0] BAUD_1 = 17'h0_0096;
	localparam logic [16:0] BAUD_2 = 17'h0_012C;
	localparam logic [16:0] BAUD_3 = 17'h0_0258;
	localparam logic [16:0] BAUD_4 = 17'h0_04B0;
	localparam logic [16:0] BAUD_5 = 17'h0_0960;
	localparam logic [16:0] BAUD_6 = 17'h0_12C0;
	localparam logic [16:0] BAUD_7 = 17'h0_2580;

	// Register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_AUTO_MS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
	localparam logic [7:0] REG_IRQ_EN = 8'h10;
	localparam logic [7:0] REG_RESULT = 8'h14;
	localparam logic [7:0] REG_STATE = 8'h18;
	localparam int CTRL_AUTO = 0;
	localparam int CTRL_READ = 1;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_TRUNC = 1;
	localparam int IRQ_EXT = 2;
	localparam logic [15:0] AUTO_MS_RST = 16'h2710; // 10 s

	typedef struct packed {
		logic baud_select_bit2;
		logic baud_select_bit1;
		logic baud_select_bit0;
		logic display_blank_switch;
		logic triple_average_switch;
		logic short_count_switch;
		logic short_polarize_switch;
		logic long_polarize_switch;
	} pms_sw_t;

	localparam pms_sw_t SW_DEFAULT = 8'hE0;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} pms_bus_req_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_POLARIZE,
		ST_EXTEND,
		ST_COUNT,
		ST_FINISH
	} pms_state_t;

endpackage

// ===== logic/pms_sequencer.sv
// Precession measurement sequencer: polarize, count, sync line, switches
`timescale 1ns/1ps
module pms_sequencer import pms_pkg::*; #(
	parameter int unsigned P_MS_CYC = MS_CYC,
	parameter int unsigned P_BLANK_MS = BLANK_MS
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire pms_bus_req_t i_bus,
	output logic [31:0] o_rd_data,
	input wire pms_sw_t i_sw,
	input wire logic i_sync_in,
	output logic o_sync_out,
	output logic o_sync_oe_n,
	input wire logic i_read_key,
	input wire logic i_key_act,
	input wire logic i_prec,
	input wire logic i_sig_ok,
	output logic o_polarize,
	output logic o_counting,
	output logic [23:0] o_field,
	output logic o_field_valid,
	output logic o_store,
	output logic o_truncated,
	output logic o_fine_res,
	output logic o_beep,
	output logic o_display_on,
	output logic [18:0] o_baud_div,
	output logic o_irq
);

	// Polarize length from the switches; short takes priority
	function automatic logic [11:0] pol_len(input pms_sw_t sw);
		if (sw.short_polarize_switch) begin
			pol_len = POL_SHORT_MS;
		end else if (sw.long_polarize_switch) begin
			pol_len = POL_LONG_MS;
		end else begin
			pol_len = POL_NORM_MS;
		end
	endfunction

	// Bit period in clocks for a baud code, rounded to nearest
	function automatic logic [18:0] baud_div(input logic [2:0] code);
		logic [16:0] rate;
		rate = BAUD_7;
		unique case (code)
			3'h0: rate = BAUD_0;
			3'h1: rate = BAUD_1;
			3'h2: rate = BAUD_2;
			3'h3: rate = BAUD_3;
			3'h4: rate = BAUD_4;
			3'h5: rate = BAUD_5;
			3'h6: rate = BAUD_6;
			3'h7: rate = BAUD_7;
		endcase
		baud_div = 19'((CLK_HZ + 32'(rate) / 2) / 32'(rate));
	endfunction

	localparam int NPIN = 13;
	localparam logic [NPIN-1:0] PIN_RST = {SW_DEFAULT, 5'h01_1};

	logic [NPIN-1:0] meta_ff;
	logic [NPIN-1:0] pin_ff;
	pms_sw_t sw;
	logic line_high;
	logic read_key;
	logic key_act;
	logic prec;
	logic sig_ok;
	logic prec_d_ff;
	logic read_d_ff;
	logic [15:0] tick_cnt_ff;
	logic tick_ff;
	pms_state_t state_ff;
	logic [11:0] ms_ff;
	logic [1:0] settle_ff;
	logic [1:0] rd_idx_ff;
	logic [15:0] edges_ff;
	logic [25:0] accum_ff;
	logic armed_ff;
	logic store_ff;
	logic trunc_ff;
	logic [15:0] auto_cnt_ff;
	logic [19:0] idle_ms_ff;
	logic [3:0] beep_left_ff;
	logic [11:0] beep_ms_ff;
	logic auto_en_ff;
	logic soft_read_ff;
	logic [15:0] auto_ms_ff;
	logic [2:0] irq_stat_ff;
	logic [2:0] irq_en_ff;
	logic [2:0] irq_ev;
	logic ext_start;
	logic own_start;
	logic start;
	logic [11:0] pol_ms;
	logic [11:0] cnt_ms;
	logic [33:0] prod;
	logic [23:0] tenths;
	logic [25:0] nxt_accum;
	logic [41:0] mean_prod;
	logic last_read;
	logic finish_out;

	// Every pin crosses two flip-flops; switches reset to the default set
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			meta_ff <= PIN_RST;
			pin_ff <= PIN_RST;
		end else begin
			meta_ff <= {i_sw, i_sync_in, i_read_key, i_key_act, i_prec,
				i_sig_ok};
			pin_ff <= meta_ff;
		end
	end

	assign sw = pin_ff[12:5];
	assign line_high = pin_ff[4];
	assign read_key = pin_ff[3];
	assign key_act = pin_ff[2];
	assign prec = pin_ff[1];
	assign sig_ok = pin_ff[0];

	// Millisecond enable; all phase timing counts these pulses
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (32'(tick_cnt_ff) == P_MS_CYC - 1) begin
			tick_cnt_ff <= '0;
			tick_ff <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 16'h0001;
			tick_ff <= 1'b0;
		end
	end

	// Start sources; an outside low only counts once the line was seen high,
	// so a line still held at cycle end does not retrigger at once
	assign ext_start = armed_ff && !line_high;
	assign own_start = (read_key && !read_d_ff) || soft_read_ff ||
		(auto_en_ff && auto_cnt_ff >= auto_ms_ff);
	assign start = (state_ff == ST_IDLE) && (ext_start || own_start);
	assign pol_ms = pol_len(sw);
	assign cnt_ms = sw.short_count_switch ? CNT_SHORT_MS : CNT_NORM_MS;

	// Scale count to tenths of nT; short window keeps even tenths only
	assign prod = edges_ff * (sw.short_count_switch ? SCALE_SHORT :
		SCALE_NORM);
	assign tenths = sw.short_count_switch ? {prod[31:9], 1'b0} :
		prod[31:8];
	assign nxt_accum = accum_ff + {2'b00, tenths};
	assign mean_prod = nxt_accum * THIRD_Q16;
	assign last_read = !sw.triple_average_switch || rd_idx_ff == AVG_LAST;
	assign finish_out = (state_ff == ST_FINISH) && last_read;

	// Edge detectors on synchronised pins
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			prec_d_ff <= 1'b0;
			read_d_ff <= 1'b0;
		end else begin
			prec_d_ff <= prec;
			read_d_ff <= read_key;
		end
	end

	// Sequencer: polarize, optional hold-over, count, finish
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			state_ff <= ST_IDLE;
			ms_ff <= '0;
			settle_ff <= '0;
			rd_idx_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: begin
					if (start) begin
						state_ff <= ST_POLARIZE;
						ms_ff <= '0;
						rd_idx_ff <= '0;
					end
				end
				ST_POLARIZE: begin
					if (ms_ff == pol_ms) begin
						state_ff <= ST_EXTEND;
						settle_ff <= '0;
					end else if (tick_ff) begin
						ms_ff <= ms_ff + 12'h001;
					end
				end
				ST_EXTEND: begin
					// Own release needs the pin pipeline to clear first
					if (settle_ff != SETTLE_CYC) begin
						settle_ff <= settle_ff + 2'h1;
					end else if (line_high ||
						ms_ff == 12'(pol_ms + EXTRA_MS)) begin
						state_ff <= ST_COUNT;
						ms_ff <= '0;
					end else if (tick_ff) begin
						ms_ff <= ms_ff + 12'h001;
					end
				end
				ST_COUNT: begin
					if (!sig_ok || ms_ff == cnt_ms) begin
						state_ff <= ST_FINISH;
					end else if (tick_ff) begin
						ms_ff <= ms_ff + 12'h001;
					end
				end
				ST_FINISH: begin
					if (last_read) begin
						state_ff <= ST_IDLE;
					end else begin
						state_ff <= ST_POLARIZE;
						ms_ff <= '0;
						rd_idx_ff <= rd_idx_ff + 2'h1;
					end
				end
			endcase
		end
	end

	// Precession edge counter and running sum for averaging
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			edges_ff <= '0;
			accum_ff <= '0;
		end else if (state_ff == ST_POLARIZE) begin
			edges_ff <= '0;
			if (rd_idx_ff == 2'h0) begin
				accum_ff <= '0;
			end
		end else if (state_ff == ST_COUNT && prec && !prec_d_ff) begin
			edges_ff <= edges_ff + 16'h0001;
		end else if (state_ff == ST_FINISH) begin
			accum_ff <= nxt_accum;
		end
	end

	// Cycle bookkeeping: rearm, store request, truncation
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			armed_ff <= 1'b0;
			store_ff <= 1'b0;
			trunc_ff <= 1'b0;
		end else if (start) begin
			armed_ff <= 1'b0;
			store_ff <= ext_start || auto_en_ff;
			trunc_ff <= 1'b0;
		end else begin
			if (state_ff == ST_IDLE && line_high) begin
				armed_ff <= 1'b1;
			end
			if (state_ff == ST_COUNT && !sig_ok && ms_ff != cnt_ms) begin
				trunc_ff <= 1'b1;
			end
		end
	end

	// Line and coil drive; the line is released with polarize time
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_sync_out <= 1'b0;
			o_sync_oe_n <= 1'b1;
			o_polarize <= 1'b0;
			o_counting <= 1'b0;
		end else begin
			o_sync_out <= 1'b0;
			o_sync_oe_n <= !(start || (state_ff == ST_POLARIZE &&
				ms_ff != pol_ms));
			o_polarize <= start || state_ff == ST_POLARIZE ||
				state_ff == ST_EXTEND;
			o_counting <= state_ff == ST_COUNT &&
				!(!sig_ok || ms_ff == cnt_ms);
		end
	end

	// Result outputs on the last reading of a cycle
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_field <= '0;
			o_field_valid <= 1'b0;
			o_store <= 1'b0;
			o_truncated <= 1'b0;
			o_fine_res <= 1'b1;
			o_baud_div <= baud_div(3'h7);
		end else begin
			o_field_valid <= finish_out;
			o_store <= finish_out && store_ff;
			if (finish_out) begin
				o_field <= sw.triple_average_switch ? mean_prod[39:16] :
					tenths;
				o_truncated <= trunc_ff;
				o_fine_res <= !sw.short_count_switch;
			end
			o_baud_div <= baud_div({sw.baud_select_bit2,
				sw.baud_select_bit1, sw.baud_select_bit0});
		end
	end

	// Five beeps: ten 100 ms half periods, sounding on even counts
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			beep_left_ff <= '0;
			beep_ms_ff <= '0;
			o_beep <= 1'b0;
		end else begin
			if (finish_out && trunc_ff) begin
				beep_left_ff <= BEEP_PHASES;
				beep_ms_ff <= '0;
			end else if (beep_left_ff != 4'h0 && tick_ff) begin
				if (beep_ms_ff == BEEP_MS - 12'h001) begin
					beep_ms_ff <= '0;
					beep_left_ff <= beep_left_ff - 4'h1;
				end else begin
					beep_ms_ff <= beep_ms_ff + 12'h001;
				end
			end
			o_beep <= beep_left_ff != 4'h0 && !beep_left_ff[0];
		end
	end

	// Auto cycle spacing and keyboard idle time for blanking
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			auto_cnt_ff <= '0;
			idle_ms_ff <= '0;
			o_display_on <= 1'b1;
		end else begin
			if (start || state_ff != ST_IDLE) begin
				auto_cnt_ff <= '0;
			end else if (tick_ff && auto_cnt_ff != 16'hFFFF) begin
				auto_cnt_ff <= auto_cnt_ff + 16'h0001;
			end
			if (key_act || read_key || !auto_en_ff) begin
				idle_ms_ff <= '0;
			end else if (tick_ff && 32'(idle_ms_ff) < P_BLANK_MS) begin
				idle_ms_ff <= idle_ms_ff + 20'h0_0001;
			end
			o_display_on <= !(auto_en_ff && sw.display_blank_switch &&
				32'(idle_ms_ff) >= P_BLANK_MS);
		end
	end

	// Register writes; the read request bit is a one-cycle command
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			auto_en_ff <= 1'b0;
			soft_read_ff <= 1'b0;
			auto_ms_ff <= AUTO_MS_RST;
			irq_en_ff <= '0;
		end else begin
			soft_read_ff <= i_bus.wr && i_bus.addr == REG_CTRL &&
				i_bus.wdata[CTRL_READ];
			if (i_bus.wr) begin
				unique case (i_bus.addr)
					REG_CTRL: auto_en_ff <= i_bus.wdata[CTRL_AUTO];
					REG_AUTO_MS: auto_ms_ff <= i_bus.wdata[15:0];
					REG_IRQ_EN: irq_en_ff <= i_bus.wdata[2:0];
					default: ;
				endcase
			end
		end
	end

	// Sticky events; a new event outranks a clear in the same cycle
	assign irq_ev = {start && ext_start, finish_out && trunc_ff,
		finish_out};

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			irq_stat_ff <= '0;
			o_irq <= 1'b0;
		end else begin
			if (i_bus.wr && i_bus.addr == REG_IRQ_CLR) begin
				irq_stat_ff <= (irq_stat_ff & ~i_bus.wdata[2:0]) | irq_ev;
			end else begin
				irq_stat_ff <= irq_stat_ff | irq_ev;
			end
			o_irq <= |(irq_stat_ff & irq_en_ff);
		end
	end

	// Read data stands in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			o_rd_data <= '0;
		end else if (i_bus.rd) begin
			unique case (i_bus.addr)
				REG_CTRL: o_rd_data <= {31'h0000_0000, auto_en_ff};
				REG_AUTO_MS: o_rd_data <= {16'h0000, auto_ms_ff};
				REG_IRQ_STAT: o_rd_data <= {29'h0000_0000, irq_stat_ff};
				REG_IRQ_EN: o_rd_data <= {29'h0000_0000, irq_en_ff};
				REG_RESULT: o_rd_data <= {o_truncated, o_fine_res, 6'h00,
					o_field};
				REG_STATE: o_rd_data <= {16'h0000, sw, 1'b0, state_ff,
					!o_sync_oe_n, line_high, rd_idx_ff};
				default: o_rd_data <= '0;
			endcase
		end else begin
			o_rd_data <= '0;
		end
	end

endmodule // pms_sequencer

// ===== verif/pms_seq_assertions.sv
// Port-level checker for the precession measurement sequencer
`timescale 1ns/1ps
module pms_seq_assertions import pms_pkg::*; #(
	parameter int unsigned P_MS_CYC = MS_CYC
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire pms_bus_req_t i_bus,
	input wire logic [31:0] o_rd_data,
	input wire pms_sw_t i_sw,
	input wire logic o_sync_out,
	input wire logic o_sync_oe_n,
	input wire logic o_polarize,
	input wire logic o_counting,
	input wire logic o_field_valid,
	input wire logic o_store,
	input wire logic o_truncated,
	input wire logic o_beep,
	input wire logic [18:0] o_baud_div
);
	localparam int unsigned POL_MAX = (POL_LONG_MS + EXTRA_MS + 2) * P_MS_CYC;
	localparam int unsigned OE_MAX = (POL_LONG_MS + 2) * P_MS_CYC;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	int unsigned pol_len_ff;
	int unsigned oe_len_ff;

	// Spell lengths, too long to unroll as repetitions
	always_ff @(posedge i_mclk) begin
		pol_len_ff <= (i_srst || !o_polarize) ? 0 : pol_len_ff + 1;
		oe_len_ff <= (i_srst || o_sync_oe_n) ? 0 : oe_len_ff + 1;
	end

	property p_sync_low;
		o_sync_out == 1'b0;
	endproperty
	a_sync_low: assert property (p_sync_low)
		else $error("sync drive level not low");
	property p_oe_in_pol;
		!o_sync_oe_n |-> o_polarize;
	endproperty
	a_oe_in_pol: assert property (p_oe_in_pol)
		else $error("line pulled outside polarize");
	property p_start;
		$fell(o_sync_oe_n) |-> $rose(o_polarize);
	endproperty
	a_start: assert property (p_start)
		else $error("line pull without polarize start");
	property p_phases;
		!(o_polarize && o_counting);
	endproperty
	a_phases: assert property (p_phases)
		else $error("coil current during count");
	property p_count_follows;
		$fell(o_polarize) |-> ##[1:8] o_counting;
	endproperty
	a_count_follows: assert property (p_count_follows)
		else $error("count did not follow polarize");
	property p_valid_pulse;
		o_field_valid |=> !o_field_valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse)
		else $error("result strobe longer than one cycle");
	property p_store;
		o_store |-> o_field_valid;
	endproperty
	a_store: assert property (p_store)
		else $error("store without result");
	property p_rd_idle;
		!$past(i_bus.rd) |-> o_rd_data == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside its cycle");
	property p_baud;
		(i_sw[7:5] == 3'h7) [*5] |-> o_baud_div == 19'h0_1047;
	endproperty
	a_baud: assert property (p_baud)
		else $error("baud divider wrong for code seven");
	property p_pol_max;
		pol_len_ff <= POL_MAX;
	endproperty
	a_pol_max: assert property (p_pol_max)
		else $error("polarize exceeded hold-over limit");
	property p_oe_max;
		oe_len_ff <= OE_MAX;
	endproperty
	a_oe_max: assert property (p_oe_max)
		else $error("line pulled past polarize time");
	property p_beep;
		o_beep |-> o_truncated;
	endproperty
	a_beep: assert property (p_beep)
		else $error("beep without truncated result");
endmodule // pms_seq_assertions

bind pms_sequencer pms_seq_assertions #(.P_MS_CYC(P_MS_CYC)) u_chk (
	.i_mclk(i_mclk), .i_srst(i_srst), .i_bus(i_bus), .o_rd_data(o_rd_data),
	.i_sw(i_sw), .o_sync_out(o_sync_out), .o_sync_oe_n(o_sync_oe_n),
	.o_polarize(o_polarize), .o_counting(o_counting),
	.o_field_valid(o_field_valid), .o_store(o_store),
	.o_truncated(o_truncated), .o_beep(o_beep), .o_baud_div(o_baud_div)
);

// ===== verif/pms_trig_model.sv
// External trigger source on the shared open-drain trigger line
`timescale 1ns/1ps
module pms_trig_model (
	input wire logic i_mclk,
	input wire logic i_oe_n,
	input wire logic [15:0] i_hold,
	input wire logic i_go,
	output logic o_line
);
	logic [15:0] low_ff = 16'h0000;

	// Sinks the line for the commanded span only, then lets go
	always @(posedge i_mclk) begin
		if (i_go)
			low_ff <= i_hold;
		else if (low_ff != 16'h0000)
			low_ff <= low_ff - 16'h0001;
	end

	// Pull-up wins unless either party sinks the line
	assign o_line = !(low_ff != 16'h0000 || !i_oe_n);
endmodule // pms_trig_model

// ===== verif/test_precession_measure_sequencer.sv
// Self-checking bench for the precession measurement sequencer
`timescale 1ns/1ps
module test_precession_measure_sequencer import pms_pkg::*;;
	localparam int MS = 4;
	logic clk = 1'b0;
	logic srst = 1'b1;
	pms_bus_req_t bus = '0;
	pms_sw_t sw = SW_DEFAULT;
	logic rd_key = 1'b0;
	logic key_act = 1'b0;
	logic prec = 1'b0;
	logic sig_ok = 1'b1;
	logic go = 1'b0;
	logic [15:0] hold = 16'h0000;
	logic line, sync_out, oe_n, pol, cnt_on, fval, store, trunc, fine;
	logic beep, disp, irq;
	logic [31:0] rd_data;
	logic [23:0] field;
	logic [18:0] baud;
	logic beep_q = 1'b0;
	logic rd_d = 1'b0;
	logic prec_q = 1'b0;
	logic [2:0] exp_q[$];
	logic [31:0] rq[$];
	int br[8] = '{115200, 150, 300, 600, 1200, 2400, 4800, 9600};
	int miscompares = 0;
	int n_tests = 0;
	int seed = 17;
	int n_oe, n_pol, n_cnt, n_beep, n_edge, i;
	logic [31:0] v;

	always #12.5 clk = ~clk;

	pms_sequencer #(.P_MS_CYC(MS), .P_BLANK_MS(20)) dut_u (
		.i_mclk(clk), .i_srst(srst), .i_bus(bus), .o_rd_data(rd_data),
		.i_sw(sw), .i_sync_in(line), .o_sync_out(sync_out),
		.o_sync_oe_n(oe_n), .i_read_key(rd_key), .i_key_act(key_act),
		.i_prec(prec), .i_sig_ok(sig_ok), .o_polarize(pol),
		.o_counting(cnt_on), .o_field(field), .o_field_valid(fval),
		.o_store(store), .o_truncated(trunc), .o_fine_res(fine),
		.o_beep(beep), .o_display_on(disp), .o_baud_div(baud), .o_irq(irq)
	);

	pms_trig_model u_trig (.i_mclk(clk), .i_oe_n(oe_n), .i_hold(hold),
		.i_go(go), .o_line(line));

	// Precession tone with a jittered half period
	always begin
		repeat (2 + ($random(seed) & 3)) @(posedge clk);
		prec <= ~prec;
	end

	// Phase lengths and beep count, taken at every rising edge
	always @(posedge clk) begin
		n_oe += !oe_n;
		n_pol += pol;
		n_cnt += cnt_on;
		n_beep += beep && !beep_q;
		beep_q <= beep;
		// Tone edges seen while the count window is open
		n_edge += cnt_on && prec && !prec_q;
		prec_q <= prec;
		rd_d <= bus.rd;
	end

	// Oldest note against each result; mid-cycle so outputs have settled
	always @(negedge clk) begin
		// Read data stands only in the cycle after the strobe
		if (fval)
			chk({store, trunc, fine},
				exp_q.size() ? exp_q.pop_front() : 4'h8);
		if (rd_d)
			chk(rd_data, rq.size() ? rq.pop_front() : 32'h0000_dead);
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Mismatches %0d of %0d checks", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Gap cycle after each access keeps every strobe a single pulse
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask

	task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask

	function automatic logic near(input int a, input int b);
		return a >= b - 40 && a <= b + 40;
	endfunction

	// One triggered measurement: by the line when h is positive, by key when zero, else by software read
	task automatic cyc(input pms_sw_t s, input int h, input logic tr,
		input int p_oe, input int p_pol, input int p_cnt);
		int k, e, t;
		logic [17:0] sc;
		sw <= s;
		repeat (8) @(posedge clk);
		n_oe = 0;
		n_pol = 0;
		n_cnt = 0;
		n_beep = 0;
		n_edge = 0;
		exp_q.push_back({h > 0, tr, !s.short_count_switch});
		// Negative hold asks for a software read through the control word
		if (h < 0)
			bus_wr(REG_CTRL, 32'h0000_0002);
		hold <= h[15:0];
		go <= h > 0;
		rd_key <= h == 0;
		repeat (4) @(posedge clk);
		go <= 1'b0;
		rd_key <= 1'b0;
		if (tr) begin
			for (k = 0; k < 20000 && !cnt_on; k++)
				@(posedge clk);
			repeat (200) @(posedge clk);
			sig_ok <= 1'b0;
		end
		for (k = 0; k < 60000 && !fval; k++)
			@(posedge clk);
		sig_ok <= 1'b1;
		chk(k < 60000, 1'b1);
		chk(near(n_oe, p_oe), 1'b1);
		chk(near(n_pol, p_pol), 1'b1);
		chk(near(n_cnt, p_cnt), 1'b1);
		// Field from our own edge count; window skew allows a few edges
		sc = s.short_count_switch ? SCALE_SHORT : SCALE_NORM;
		e = (n_edge * sc) >> 8;
		if (s.triple_average_switch)
			e = e / 3;
		t = (3 * sc) >> 8;
		chk(field >= e - t && field <= e + t, 1'b1);
	endtask

	// Watchdog sized above the longest expected run
	initial begin
		repeat (95000) @(posedge clk);
		miscompares++;
		close_out();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk(baud, 19'h0_1047);
		chk({oe_n, fine, disp}, 3'h7);
		bus_rd(REG_AUTO_MS, 32'h0000_2710);
		v = $random(seed) & 32'h0000_ffff;
		bus_wr(REG_AUTO_MS, v);
		bus_rd(REG_AUTO_MS, v);
		bus_rd(8'hFC, 32'h0000_0000);
		for (i = 0; i < 8; i++) begin
			sw <= {i[2:0], 5'h00};
			repeat (6) @(posedge clk);
			chk(baud, (40_000_000 + br[i] / 2) / br[i]);
		end
		bus_wr(REG_IRQ_EN, 32'h0000_0007);
		cyc(8'hE6, 20, 0, POL_SHORT_MS * MS, POL_SHORT_MS * MS, 1840);
		repeat (3) @(posedge clk);
		chk(irq, 1'b1);
		bus_rd(REG_IRQ_STAT, 32'h0000_0005);
		bus_wr(REG_IRQ_EN, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		bus_wr(REG_IRQ_EN, 32'h0000_0007);
		bus_wr(REG_IRQ_CLR, 32'h0000_0007);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		cyc(8'hE6, 5000, 0, POL_SHORT_MS * MS, 5005, 1840);
		cyc(8'hE6, 9000, 0, POL_SHORT_MS * MS, 7600, 1840);
		cyc(8'hEE, 0, 0, 10800, 10800, 5520);
		cyc(SW_DEFAULT, -1, 0, 7200, 7200, CNT_NORM_MS * MS);
		cyc(8'hE5, 0, 0, 11600, 11600, 1840);
		bus_wr(REG_IRQ_CLR, 32'h0000_0007);
		cyc(8'hE3, 0, 1, POL_SHORT_MS * MS, 3600, 205);
		repeat (4400) @(posedge clk);
		chk(n_beep, 5);
		bus_rd(REG_IRQ_STAT, 32'h0000_0003);
		sw <= 8'hF6;
		bus_wr(REG_CTRL, 32'h0000_0001);
		bus_rd(REG_CTRL, 32'h0000_0001);
		repeat (200) @(posedge clk);
		chk(disp, 1'b0);
		key_act <= 1'b1;
		repeat (6) @(posedge clk);
		chk(disp, 1'b1);
		close_out();
	end
endmodule // test_precession_measure_sequencer
